// file: bst_consts.svh
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// Scan register lengths
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BND_W 109

// Instruction codes
`define BST_INS_EXTEST 3'h0
`define BST_INS_IDCODE 3'h1
`define BST_INS_SAMPLE 3'h4
`define BST_INS_BYPASS 3'h7

// Fixed pattern captured into the instruction shifter
`define BST_IR_CAPTURE 3'h1

// Identification value; arbitrary, bit 0 must stay set
`define BST_ID_DEFAULT 32'h0ABC_D001

`endif

// file: bst_pkg.sv
package bst_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHF_DR,
    ST_EX1_DR,
    ST_PAU_DR,
    ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHF_IR,
    ST_EX1_IR,
    ST_PAU_IR,
    ST_EX2_IR,
    ST_UPD_IR
  } bst_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } bst_pin_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_pin_out_t;

endpackage

// file: bst_tap.sv
`timescale 1ns/10ps
`include "bst_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module bst_tap #(
  parameter logic [`BST_ID_W-1:0] ID_VALUE = `BST_ID_DEFAULT,
  parameter int BND_W = `BST_BND_W
) (
  // System clock domain
  input wire logic clk,
  input wire logic rst,
  input wire logic [BND_W-1:0] io_ring,
  // Test link
  input wire logic tck,
  input wire bst_pkg::bst_pin_in_t pin_in,
  output bst_pkg::bst_pin_out_t pin_out
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: pin synchroniser and snapshot handshake

  logic [BND_W-1:0] ring_m_q;
  logic [BND_W-1:0] ring_s_q;
  logic [BND_W-1:0] shadow_q;
  logic req_q;
  logic ack_m_q;
  logic ack_s_q;
  logic por_q;
  logic por_ack_m_q;
  logic por_ack_s_q;
  // Test-domain crossing flops, declared here as the system side reads por_s_q and ack_t_q
  logic por_m_q;
  logic por_s_q;
  logic req_m_q;
  logic req_s_q;
  logic ack_t_q;
  logic [BND_W-1:0] ring_t_q;

  // Ring pins are asynchronous to clk
  always_ff @(posedge clk) begin
    ring_m_q <= io_ring;
    ring_s_q <= ring_m_q;
  end

  // Shadow only changes while the test side has acknowledged, so it is
  // stable whenever the test side copies it
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= 1'b0;
      shadow_q <= '0;
    end else if (req_q == ack_s_q) begin
      shadow_q <= ring_s_q;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_t_q;
      ack_s_q <= ack_m_q;
    end
  end

  // Power-up request held until the test side has seen it, since the
  // test clock may be slow or stopped while rst is asserted
  always_ff @(posedge clk) begin
    if (rst) begin
      por_q <= 1'b1;
    end else if (por_ack_s_q) begin
      por_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      por_ack_m_q <= 1'b0;
      por_ack_s_q <= 1'b0;
    end else begin
      por_ack_m_q <= por_s_q;
      por_ack_s_q <= por_ack_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test domain: crossings

  always_ff @(posedge tck) begin
    por_m_q <= por_q;
    por_s_q <= por_m_q;
  end

  always_ff @(posedge tck) begin
    req_m_q <= req_q;
    req_s_q <= req_m_q;
  end

  always_ff @(posedge tck) begin
    if (por_s_q) begin
      ack_t_q <= 1'b0;
      ring_t_q <= '0;
    end else if (req_s_q != ack_t_q) begin
      ring_t_q <= shadow_q;
      ack_t_q <= ~ack_t_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // TAP controller

  bst_pkg::bst_state_t state_q;
  bst_pkg::bst_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      bst_pkg::ST_RESET: begin
        state_d = pin_in.tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      end
      bst_pkg::ST_IDLE: begin
        state_d = pin_in.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      end
      bst_pkg::ST_SEL_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      end
      bst_pkg::ST_CAP_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
      end
      bst_pkg::ST_SHF_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
      end
      bst_pkg::ST_EX1_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      end
      bst_pkg::ST_PAU_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      end
      bst_pkg::ST_EX2_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHF_DR;
      end
      bst_pkg::ST_UPD_DR: begin
        state_d = pin_in.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      end
      // Five high samples from any state end in ST_RESET
      bst_pkg::ST_SEL_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      end
      bst_pkg::ST_CAP_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
      end
      bst_pkg::ST_SHF_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
      end
      bst_pkg::ST_EX1_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      end
      bst_pkg::ST_PAU_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      end
      bst_pkg::ST_EX2_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHF_IR;
      end
      bst_pkg::ST_UPD_IR: begin
        state_d = pin_in.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      end
      default: begin
        state_d = bst_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge tck) begin
    if (por_s_q) begin
      state_q <= bst_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register

  logic [`BST_IR_W-1:0] ir_q;
  logic [`BST_IR_W-1:0] ir_sh_q;

  always_ff @(posedge tck) begin
    if (state_q == bst_pkg::ST_CAP_IR) begin
      ir_sh_q <= `BST_IR_CAPTURE;
    end else if (state_q == bst_pkg::ST_SHF_IR) begin
      ir_sh_q <= {pin_in.tdi, ir_sh_q[`BST_IR_W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (por_s_q || state_q == bst_pkg::ST_RESET) begin
      ir_q <= `BST_INS_IDCODE;
    end else if (state_q == bst_pkg::ST_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // Only EXTEST, SAMPLE and IDCODE reach a data register; every other
  // code, including the spare ones, selects bypass
  logic sel_id;
  logic sel_bnd;

  always_comb begin
    sel_id = (ir_q == `BST_INS_IDCODE);
    sel_bnd = (ir_q == `BST_INS_EXTEST) || (ir_q == `BST_INS_SAMPLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers

  logic byp_q;
  logic [`BST_ID_W-1:0] id_sh_q;
  logic [BND_W-1:0] bnd_sh_q;
  logic cap_dr;
  logic shf_dr;

  always_comb begin
    cap_dr = (state_q == bst_pkg::ST_CAP_DR);
    shf_dr = (state_q == bst_pkg::ST_SHF_DR);
  end

  always_ff @(posedge tck) begin
    if (cap_dr) begin
      byp_q <= 1'b0;
    end else if (shf_dr) begin
      byp_q <= pin_in.tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (cap_dr && sel_id) begin
      id_sh_q <= ID_VALUE;
    end else if (shf_dr && sel_id) begin
      id_sh_q <= {pin_in.tdi, id_sh_q[`BST_ID_W-1:1]};
    end
  end

  // The ring copy can be up to a few test clocks old; a stable ring is
  // assumed around Capture-DR
  always_ff @(posedge tck) begin
    if (cap_dr && sel_bnd) begin
      bnd_sh_q <= ring_t_q;
    end else if (shf_dr && sel_bnd) begin
      bnd_sh_q <= {pin_in.tdi, bnd_sh_q[BND_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output on the falling edge

  logic tdo_d;

  // Pause and Exit states keep the shifters untouched, so the bit shown
  // after a detour is the one that was next before it
  always_comb begin
    if (state_q == bst_pkg::ST_SHF_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (sel_id) begin
      tdo_d = id_sh_q[0];
    end else if (sel_bnd) begin
      tdo_d = bnd_sh_q[0];
    end else begin
      tdo_d = byp_q;
    end
  end

  // Pin released while the power-up request is seen, so a board that
  // starts the test clock late never meets a driven output
  always_ff @(negedge tck) begin
    if (por_s_q) begin
      pin_out.tdo <= 1'b0;
      pin_out.tdo_oe <= 1'b0;
    end else begin
      pin_out.tdo <= tdo_d;
      pin_out.tdo_oe <= shf_dr || (state_q == bst_pkg::ST_SHF_IR);
    end
  end

endmodule

// file: bst_tap_checker.sv
`timescale 1ns/10ps
`include "bst_consts.svh"
module bst_tap_checker #(
  parameter logic [`BST_ID_W-1:0] ID_VALUE = `BST_ID_DEFAULT,
  parameter int BND_W = `BST_BND_W
) (
  // System side
  input wire logic clk,
  input wire logic rst,
  input wire logic [BND_W-1:0] io_ring,
  // Test link
  input wire logic tck,
  input wire bst_pkg::bst_pin_in_t pin_in,
  input wire bst_pkg::bst_pin_out_t pin_out
);
  wire logic m = pin_in.tms;
  wire logic oe = pin_out.tdo_oe;
  AST_OUT_FALL: assert property (@(posedge clk) disable iff (rst)
    tck && $past(tck) |-> $stable(pin_out)) else $error("tdo moved at rise");
  AST_PWRUP: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##[1:400] !oe) else $error("no power-up reset");
  AST_RST5: assert property (@(posedge tck) disable iff (rst)
    m [*5] |=> !oe) else $error("no reset after five highs");
  AST_SHIFT_IN: assert property (@(posedge tck) disable iff (rst)
    $rose(oe) |-> !$past(m)) else $error("bad shift entry");
  AST_SHIFT_OUT: assert property (@(posedge tck) disable iff (rst)
    oe && m |=> !oe) else $error("shift not left");
  AST_SHIFT_HOLD: assert property (@(posedge tck) disable iff (rst)
    oe && !m |=> oe) else $error("shift left early");
  AST_ID_FIRST: assert property (@(posedge tck) disable iff (rst)
    m [*5] ##1 !m ##1 m ##1 !m [*2] |=> oe && pin_out.tdo == ID_VALUE[0])
    else $error("bad first id bit");
  AST_IR_CAP: assert property (@(posedge tck) disable iff (rst)
    m [*5] ##1 !m ##1 m [*2] ##1 !m [*2] |=> oe && pin_out.tdo == 1'b1)
    else $error("bad ir capture");
  cover property (@(posedge tck) $rose(oe));
  cover property (@(posedge tck) oe && m);
  cover property (@(posedge tck) m [*5]);
  cover property (@(posedge tck) $fell(oe) ##4 $rose(oe));
endmodule
bind bst_tap bst_tap_checker #(.ID_VALUE(ID_VALUE), .BND_W(BND_W)) u_chk (.clk(clk),
  .rst(rst), .io_ring(io_ring), .tck(tck), .pin_in(pin_in), .pin_out(pin_out));

// file: bst_ctl_model.sv
`timescale 1ns/10ps
module bst_ctl_model (
  // Test link
  output logic tck,
  output bst_pkg::bst_pin_in_t pin_in,
  input wire bst_pkg::bst_pin_out_t pin_out
);
  initial begin
    tck = 1'b0;
    pin_in = '1;
  end
  // Clock runs only inside a step; tdi flips after hold so a stale bit never passes
  task automatic step(input logic m, input logic d);
    pin_in = {m, d};
    #32 tck = 1'b1;
    #16 pin_in.tdi = ~d;
    #16 tck = 1'b0;
  endtask
endmodule

// file: boundary_scan_tap_tb.sv
`timescale 1ns/10ps
`include "bst_consts.svh"
module boundary_scan_tap_tb;
  localparam logic [31:0] ID = 32'h5A5A_0F0F; // Arbitrary value, bit 0 set
  localparam logic [2:0] INS [5] = '{3'h0, 3'h1, 3'h4, 3'h7, 3'h2};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [108:0] io_ring = '0;
  logic tck;
  bst_pkg::bst_pin_in_t pin_in;
  bst_pkg::bst_pin_out_t pin_out;
  logic [127:0] d;
  logic q[$];
  logic armed = 1'b0;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  bst_tap #(.ID_VALUE(ID)) u_dut (.clk(clk), .rst(rst), .io_ring(io_ring), .tck(tck),
    .pin_in(pin_in), .pin_out(pin_out));
  bst_ctl_model u_ctl (.tck(tck), .pin_in(pin_in), .pin_out(pin_out));
  task automatic check(logic seen, logic exp, string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %b seen %b", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d of %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Every driven bit must have been announced first
  always @(posedge tck) begin
    // Outputs are undefined until the first power-up reset has run
    if (armed && pin_out.tdo_oe !== 1'b0) begin
      check(pin_out.tdo_oe, q.size() > 0, "tdo_oe");
      if (q.size() > 0) check(pin_out.tdo, q.pop_front(), "tdo");
    end
  end
  task automatic scan(logic ir, int n, logic [127:0] di, e, int p = -1);
    u_ctl.step(1'b1, 1'b0);
    if (ir) u_ctl.step(1'b1, 1'b0);
    repeat (2) u_ctl.step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      q.push_back(e[i]);
      u_ctl.step(i == n - 1 || i == p, di[i]);
      // Detour through Pause and Exit2 must keep the shifted bits intact
      if (i == p && i < n - 1) begin
        repeat (2) u_ctl.step(1'b0, 1'b0);
        u_ctl.step(1'b1, 1'b0);
        u_ctl.step(1'b0, 1'b0);
      end
    end
    u_ctl.step(1'b1, 1'b0);
    u_ctl.step(1'b0, 1'b0);
    check(q.size() == 0, 1'b1, "length");
  endtask
  task automatic power_up();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    #1.3;
    repeat (8) u_ctl.step(1'b0, 1'b0);
    armed = 1'b1;
  endtask
  task automatic tms_reset();
    repeat (5) u_ctl.step(1'b1, 1'($urandom));
    u_ctl.step(1'b0, 1'b0);
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(75827));
    d = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk);
    io_ring <= d[108:0];
    power_up();
    scan(1'b0, 32, d, ID, 13);
    foreach (INS[k]) begin
      scan(1'b1, 3, INS[k], 3'h1);
      d = {$urandom, $urandom, $urandom, $urandom};
      if (INS[k] == 3'h1) scan(1'b0, 36, d, {d[3:0], ID});
      else if (INS[k] inside {3'h0, 3'h4}) scan(1'b0, 111, d, {d[1:0], io_ring});
      else scan(1'b0, 8, d, {d[6:0], 1'b0});
    end
    scan(1'b1, 3, 3'h7, 3'h1, 1);
    power_up();
    scan(1'b0, 32, d, ID);
    tms_reset();
    scan(1'b1, 3, 3'h7, 3'h1);
    tms_reset();
    scan(1'b0, 32, d, ID);
    print_verdict();
  end
endmodule
